// ==== hdl/ffs_pkg.sv ====
// Purpose: Shared constants and types for the diskette function sequencer
// Assumes: 12-bit words held in [11:0], word bit 0 of the host numbering is [11]
// Notes:   Wishbone byte offsets, one 32-bit word per register
package ffs_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD   = 8'h00;
  localparam logic [7:0] ADDR_DATA  = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_CTRL  = 8'h0C;

  // Flag register bits; a write of 1 clears done, transfer request, error
  localparam int FL_DONE = 0;
  localparam int FL_TR   = 1;
  localparam int FL_ERR  = 2;
  localparam int FL_IE   = 3;
  localparam int FL_IRQ  = 4;

  // Control register bits
  localparam int CT_IE   = 0;
  localparam int CT_INIT = 1;

  // ----------------------------------------------------------------------
  // Command word fields and parity
  // ----------------------------------------------------------------------
  localparam int CMD_FN_LSB = 1;
  localparam int CMD_DRV    = 4;
  localparam int CMD_MODE   = 6;
  localparam int PAR_BIT    = 12;

  typedef enum logic [2:0] {
    FN_FILL  = 3'h0,
    FN_EMPTY = 3'h1,
    FN_WRITE = 3'h2,
    FN_READ  = 3'h3,
    FN_NONE  = 3'h4,
    FN_RSTAT = 3'h5,
    FN_WDEL  = 3'h6,
    FN_RERR  = 3'h7
  } ffs_fn_t;

  // ----------------------------------------------------------------------
  // Status word masks and reset values
  // ----------------------------------------------------------------------
  localparam logic [11:0] MASK_CRC   = 12'h001;
  localparam logic [11:0] MASK_PAR   = 12'h002;
  localparam logic [11:0] MASK_ID    = 12'h004;
  localparam logic [11:0] MASK_DD    = 12'h040;
  localparam logic [11:0] MASK_RDY   = 12'h080;
  localparam logic [11:0] STATUS_RST = 12'h000;

  localparam logic [7:0] TRACK_MAX  = 8'h4C;
  localparam logic [6:0] BUF_LAST8  = 7'h7F;
  localparam int         WORDS12    = 64;

  // Failure codes for the read-error-code command
  localparam logic [7:0] ERRC_NONE  = 8'h00;
  localparam logic [7:0] ERRC_TRACK = 8'h01;
  localparam logic [7:0] ERRC_SEEK  = 8'h02;
  localparam logic [7:0] ERRC_CRC   = 8'h03;
  localparam logic [7:0] ERRC_PAR   = 8'h04;

  // ----------------------------------------------------------------------
  // Drive command carrier
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DOP_WRITE = 2'h0,
    DOP_READ  = 2'h1,
    DOP_INIT  = 2'h2
  } ffs_dop_t;

  typedef struct packed {
    ffs_dop_t   op;
    logic       sel;
    logic       del;
    logic [6:0] track;
    logic [4:0] sector;
  } ffs_drv_cmd_t;

  localparam logic [6:0] INIT_TRACK  = 7'h01;
  localparam logic [4:0] INIT_SECTOR = 5'h01;

endpackage

// ==== hdl/ffs_sequencer.sv ====
// Purpose: Function-level command sequencer of a diskette subsystem
// Assumes: Drive logic on clk_i; power-good pin asynchronous
// Notes:   One interface register carries data, address and status; commands have their own
//
// Summary of operation
// - Command with good parity in done state drops completion
// - All three function bits decoded
// - Fill requests each word, 64 or 128
// - Completion only after whole buffer filled
// - Data reads after completion return status
// - Completion with enable raises interrupt
// - Empty clears errors, presents each word
// - Empty and write keep buffer intact
// - Write collects sector then track address
// - Bad track sets error and completion
// - Write seeks, writes, reports seek failures
// - Read clears bits, collects addresses, loads buffer
// - Check failure and deleted mark flagged
// - Read status presents status, sets completion
// - Write deleted reports deleted bit
// - Read error code presents failure code
// - Power loss unloads head, aborts everything
// - Power return runs initialize sequence
// - Initialize aborts any unfinished function
// - Command bit selects word length, twelve default
// - Command bit selects drive
// - Parity failure on command, sector or track word terminates with error
`timescale 1ns/1ps
module ffs_sequencer #(
  parameter int WORDS_12 = ffs_pkg::WORDS12
) (
  input  wire logic                  clk_i,            // 200 MHz clock
  input  wire logic                  rst_i,            // Sync reset, high
  input  wire logic                  wb_cyc_i,         // Bus cycle
  input  wire logic                  wb_stb_i,         // Bus strobe
  input  wire logic                  wb_we_i,          // Write enable
  input  wire logic [7:0]            wb_adr_i,         // Byte address
  input  wire logic [3:0]            wb_sel_i,         // Byte lanes
  input  wire logic [31:0]           wb_dat_i,         // Write data
  output logic      [31:0]           wb_dat_o,         // Read data
  output logic                       wb_ack_o,         // Acknowledge
  output logic                       irq_o,            // Interrupt request
  input  wire logic                  pwr_ok_i,         // Supply good pin
  output logic                       head_unload_o,    // Unload heads
  output ffs_pkg::ffs_drv_cmd_t      drv_cmd_o,        // Drive operation
  output logic                       drv_req_o,        // Drive request level
  input  wire logic                  drv_ack_i,        // Drive done pulse
  input  wire logic                  drv_seek_err_i,   // Seek failed
  input  wire logic                  drv_crc_err_i,    // Check char failed
  input  wire logic                  drv_dd_i,         // Deleted mark seen
  input  wire logic                  drv_rdy_i,        // Selected drive ready
  input  wire logic [6:0]            drv_buf_addr_i,   // Buffer address
  input  wire logic                  drv_buf_we_i,     // Buffer write
  input  wire logic [11:0]           drv_buf_wdata_i,  // Buffer write data
  output logic      [11:0]           drv_buf_rdata_o   // Buffer read data
);

  if (WORDS_12 < 1 || WORDS_12 > 64) begin : g_chk
    $error("WORDS_12 must lie in 1..64");
  end

  // ----------------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_DONE   = 4'h0,
    S_DECODE = 4'h1,
    S_FILL   = 4'h3,
    S_EMPTY  = 4'h2,
    S_SECT   = 4'h6,
    S_TRK    = 4'h7,
    S_DRIVE  = 4'h5,
    S_INIT   = 4'h4,
    S_PWRDN  = 4'hC
  } ffs_state_t;

  ffs_state_t       st;
  ffs_pkg::ffs_fn_t fn;
  logic [11:0]      ir;
  logic [11:0]      status;
  logic [11:0]      next_drv_status;
  logic [7:0]       errc;
  logic             done;
  logic             tr;
  logic             err;
  logic             ie;
  logic             mode8;
  logic [6:0]       idx;
  logic [11:0]      mem [0:127];
  logic             pwr_meta;
  logic             pwr_ok;
  logic             pwr_prev;
  logic             ack;
  logic             take;
  logic             wr_cmd;
  logic             wr_data;
  logic             rd_data;
  logic             wr_flags;
  logic             init_cmd;
  logic             pwr_lost;
  logic             pwr_back;
  logic             buf_we;
  logic             data_par_ok;
  logic [11:0]      rd_word;

  function automatic logic par_ok(input logic [12:0] w);
    return ^w;
  endfunction

  function automatic logic is_last(input logic [6:0] i, input logic m8);
    return m8 ? (i == ffs_pkg::BUF_LAST8) : (i == 7'(WORDS_12 - 1));
  endfunction

  // ----------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------
  assign take     = wb_cyc_i & wb_stb_i & ~ack;
  assign wr_cmd   = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == ffs_pkg::ADDR_CMD);
  assign wr_data  = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == ffs_pkg::ADDR_DATA);
  assign rd_data  = take & ~wb_we_i & (wb_adr_i == ffs_pkg::ADDR_DATA);
  assign wr_flags = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == ffs_pkg::ADDR_FLAGS);
  assign init_cmd = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == ffs_pkg::ADDR_CTRL)
                  & wb_dat_i[ffs_pkg::CT_INIT];
  assign data_par_ok = par_ok(wb_dat_i[ffs_pkg::PAR_BIT:0]);
  assign wb_ack_o = ack;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack      <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack <= take;
      if (take && !wb_we_i) begin
        case (wb_adr_i)
          ffs_pkg::ADDR_DATA:  wb_dat_o <= {20'h0_0000, ir};
          ffs_pkg::ADDR_FLAGS: wb_dat_o <= {27'h000_0000, irq_o, ie, err, tr, done};
          ffs_pkg::ADDR_CTRL:  wb_dat_o <= {31'h0000_0000, ie};
          default:             wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Interrupt enable; initialize clears it along with the flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ie <= 1'b0;
    end else if (init_cmd) begin
      ie <= 1'b0;
    end else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == ffs_pkg::ADDR_CTRL) begin
      ie <= wb_dat_i[ffs_pkg::CT_IE];
    end
  end

  assign irq_o = done & ie;

  // ----------------------------------------------------------------------
  // Power-good synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_meta <= 1'b0;
      pwr_ok   <= 1'b0;
      pwr_prev <= 1'b0;
    end else begin
      pwr_meta <= pwr_ok_i;
      pwr_ok   <= pwr_meta;
      pwr_prev <= pwr_ok;
    end
  end

  assign pwr_lost = pwr_prev & ~pwr_ok;
  assign pwr_back = ~pwr_prev & pwr_ok;

  // ----------------------------------------------------------------------
  // Sector buffer
  // ----------------------------------------------------------------------
  // Drive may only load the buffer on read and initialize operations
  assign buf_we = ((st == S_FILL) && wr_data && !tr)
                | ((st == S_DRIVE || st == S_INIT) && drv_buf_we_i
                   && drv_cmd_o.op != ffs_pkg::DOP_WRITE);

  always_ff @(posedge clk_i) begin
    if ((st == S_FILL) && wr_data && !tr) begin
      mem[idx] <= mode8 ? {4'h0, wb_dat_i[7:0]} : wb_dat_i[11:0];
    end else if (buf_we) begin
      mem[drv_buf_addr_i] <= drv_buf_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    drv_buf_rdata_o <= mem[drv_buf_addr_i];
  end

  assign rd_word = mem[idx + 7'h01];

  always_comb begin
    next_drv_status = status;
    if (drv_crc_err_i) begin
      next_drv_status = next_drv_status | ffs_pkg::MASK_CRC;
    end
    if (drv_dd_i || drv_cmd_o.del) begin
      next_drv_status = next_drv_status | ffs_pkg::MASK_DD;
    end
  end

  // ----------------------------------------------------------------------
  // Function sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st            <= S_PWRDN;
      fn            <= ffs_pkg::FN_FILL;
      ir            <= ffs_pkg::STATUS_RST;
      status        <= ffs_pkg::STATUS_RST;
      errc          <= ffs_pkg::ERRC_NONE;
      done          <= 1'b0;
      tr            <= 1'b0;
      err           <= 1'b0;
      mode8         <= 1'b0;
      idx           <= 7'h00;
      drv_req_o     <= 1'b0;
      drv_cmd_o     <= '0;
      head_unload_o <= 1'b1;
    end else begin
      // Clears first so that a same-cycle set wins
      if (wr_flags && wb_dat_i[ffs_pkg::FL_DONE]) begin
        done <= 1'b0;
      end
      if (wr_flags && wb_dat_i[ffs_pkg::FL_TR]) begin
        tr <= 1'b0;
      end
      if (wr_flags && wb_dat_i[ffs_pkg::FL_ERR]) begin
        err <= 1'b0;
      end
      if (pwr_lost) begin
        st            <= S_PWRDN;
        done          <= 1'b0;
        tr            <= 1'b0;
        drv_req_o     <= 1'b0;
        head_unload_o <= 1'b1;
      end else if ((st == S_PWRDN && pwr_back) || (st != S_PWRDN && init_cmd)) begin
        st            <= S_INIT;
        done          <= 1'b0;
        tr            <= 1'b0;
        err           <= 1'b0;
        status        <= ffs_pkg::STATUS_RST;
        errc          <= ffs_pkg::ERRC_NONE;
        mode8         <= 1'b0;
        idx           <= 7'h00;
        head_unload_o <= 1'b0;
        drv_req_o     <= 1'b1;
        drv_cmd_o     <= '{op: ffs_pkg::DOP_INIT, sel: 1'b0, del: 1'b0,
                           track: ffs_pkg::INIT_TRACK, sector: ffs_pkg::INIT_SECTOR};
      end else begin
        case (st)
          S_DONE: begin
            if (wr_cmd) begin
              done <= 1'b0;
              if (!data_par_ok) begin
                status <= status | ffs_pkg::MASK_PAR;
                ir     <= status | ffs_pkg::MASK_PAR;
                errc   <= ffs_pkg::ERRC_PAR;
                err    <= 1'b1;
                done   <= 1'b1;
              end else begin
                fn            <= ffs_pkg::ffs_fn_t'(wb_dat_i[ffs_pkg::CMD_FN_LSB +: 3]);
                drv_cmd_o.sel <= wb_dat_i[ffs_pkg::CMD_DRV];
                mode8         <= wb_dat_i[ffs_pkg::CMD_MODE];
                status        <= status & ~ffs_pkg::MASK_ID;
                err           <= 1'b0;
                st            <= S_DECODE;
              end
            end
          end
          S_DECODE: begin
            idx <= 7'h00;
            case (fn)
              ffs_pkg::FN_FILL: begin
                tr <= 1'b1;
                st <= S_FILL;
              end
              ffs_pkg::FN_EMPTY: begin
                status <= status & ~(ffs_pkg::MASK_PAR | ffs_pkg::MASK_CRC);
                ir     <= mem[0];
                tr     <= 1'b1;
                st     <= S_EMPTY;
              end
              ffs_pkg::FN_WRITE, ffs_pkg::FN_WDEL: begin
                status        <= status & ~(ffs_pkg::MASK_PAR | ffs_pkg::MASK_CRC);
                drv_cmd_o.op  <= ffs_pkg::DOP_WRITE;
                drv_cmd_o.del <= (fn == ffs_pkg::FN_WDEL);
                tr            <= 1'b1;
                st            <= S_SECT;
              end
              ffs_pkg::FN_READ: begin
                status        <= status & ~(ffs_pkg::MASK_DD | ffs_pkg::MASK_PAR
                                            | ffs_pkg::MASK_CRC);
                drv_cmd_o.op  <= ffs_pkg::DOP_READ;
                drv_cmd_o.del <= 1'b0;
                tr            <= 1'b1;
                st            <= S_SECT;
              end
              ffs_pkg::FN_RSTAT: begin
                ir   <= (status & ~(ffs_pkg::MASK_ID | ffs_pkg::MASK_RDY))
                        | (drv_rdy_i ? ffs_pkg::MASK_RDY : 12'h000);
                done <= 1'b1;
                st   <= S_DONE;
              end
              ffs_pkg::FN_RERR: begin
                ir   <= {4'h0, errc};
                done <= 1'b1;
                st   <= S_DONE;
              end
              default: begin
                ir   <= status;
                done <= 1'b1;
                st   <= S_DONE;
              end
            endcase
          end
          S_FILL: begin
            if (wr_data && !tr) begin
              idx <= idx + 7'h01;
              if (is_last(idx, mode8)) begin
                ir   <= status;
                done <= 1'b1;
                st   <= S_DONE;
              end else begin
                tr <= 1'b1;
              end
            end
          end
          S_EMPTY: begin
            if (rd_data && !tr) begin
              idx <= idx + 7'h01;
              if (is_last(idx, mode8)) begin
                ir   <= status;
                done <= 1'b1;
                st   <= S_DONE;
              end else begin
                ir <= rd_word;
                tr <= 1'b1;
              end
            end
          end
          S_SECT: begin
            if (wr_data && !tr) begin
              if (!data_par_ok) begin
                status <= status | ffs_pkg::MASK_PAR;
                ir     <= status | ffs_pkg::MASK_PAR;
                errc   <= ffs_pkg::ERRC_PAR;
                err    <= 1'b1;
                done   <= 1'b1;
                st     <= S_DONE;
              end else begin
                drv_cmd_o.sector <= wb_dat_i[4:0];
                tr               <= 1'b1;
                st               <= S_TRK;
              end
            end
          end
          S_TRK: begin
            if (wr_data && !tr) begin
              if (!data_par_ok) begin
                status <= status | ffs_pkg::MASK_PAR;
                ir     <= status | ffs_pkg::MASK_PAR;
                errc   <= ffs_pkg::ERRC_PAR;
                err    <= 1'b1;
                done   <= 1'b1;
                st     <= S_DONE;
              end else if (wb_dat_i[7:0] > ffs_pkg::TRACK_MAX) begin
                ir   <= status;
                errc <= ffs_pkg::ERRC_TRACK;
                err  <= 1'b1;
                done <= 1'b1;
                st   <= S_DONE;
              end else begin
                drv_cmd_o.track <= wb_dat_i[6:0];
                drv_req_o       <= 1'b1;
                st              <= S_DRIVE;
              end
            end
          end
          S_DRIVE: begin
            if (drv_ack_i) begin
              drv_req_o <= 1'b0;
              status    <= next_drv_status;
              ir        <= next_drv_status;
              err       <= drv_seek_err_i | drv_crc_err_i;
              errc      <= drv_seek_err_i ? ffs_pkg::ERRC_SEEK
                         : drv_crc_err_i ? ffs_pkg::ERRC_CRC : errc;
              done      <= 1'b1;
              st        <= S_DONE;
            end
          end
          S_INIT: begin
            if (drv_ack_i) begin
              drv_req_o <= 1'b0;
              status    <= ffs_pkg::MASK_ID;
              ir        <= ffs_pkg::MASK_ID;
              done      <= 1'b1;
              st        <= S_DONE;
            end
          end
          S_PWRDN: begin
            drv_req_o <= 1'b0;
          end
          default: begin
            st <= S_DONE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_cmd_drops_done: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == S_DONE && wr_cmd && !pwr_lost && !init_cmd && data_par_ok)
      |=> !done && st == S_DECODE) else $error("command did not drop completion");

  a_irq_on_done: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == S_FILL && wr_data && !tr && is_last(idx, mode8) && ie && !pwr_lost)
      |=> irq_o) else $error("missing interrupt");

  a_fill_no_done: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == S_FILL && !(wr_data && !tr && is_last(idx, mode8)))
      |=> !done || st != S_DONE) else $error("completion before buffer full");

  a_track_range: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == S_TRK && wr_data && !tr && data_par_ok && !pwr_lost && !init_cmd
     && wb_dat_i[7:0] > ffs_pkg::TRACK_MAX)
      |=> err && done && !drv_req_o) else $error("bad track not refused");

  a_empty_keeps_buf: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == S_EMPTY || (st == S_DRIVE && drv_cmd_o.op == ffs_pkg::DOP_WRITE))
      |-> !buf_we) else $error("buffer written during empty or write");

  a_pwr_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr_lost |=> st == S_PWRDN && !drv_req_o && head_unload_o && !done)
    else $error("power loss not handled");

  a_init_done: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == S_INIT && drv_ack_i && !pwr_lost && !init_cmd)
      |=> done && status == ffs_pkg::MASK_ID && !err) else $error("init did not finish");

  a_sect_to_trk: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == S_SECT && wr_data && !tr && data_par_ok && !pwr_lost && !init_cmd)
      |=> st == S_TRK && tr) else $error("track request missing");

  a_par_error: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == S_DONE && wr_cmd && !data_par_ok && !pwr_lost && !init_cmd)
      |=> err && done && (ir & ffs_pkg::MASK_PAR) != 12'h000)
    else $error("parity failure not reported");

  a_init_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    (init_cmd && st != S_PWRDN && !pwr_lost)
      |=> st == S_INIT && !done && !tr && !mode8) else $error("init did not abort");

endmodule

// ==== tb/ffs_drive_model.sv ====
// Purpose: Drive-side partner answering sequencer requests
// Assumes: Request level held until the cycle after the done pulse
// Notes:   Answer delay set per operation by the bench
`timescale 1ns/1ps
module ffs_drive_model (
  input  wire logic       clk_i,  // Clock
  input  wire logic       rst_i,  // Sync reset, high
  input  wire logic       req_i,  // Operation request level
  input  wire logic [3:0] dly_i,  // Cycles before answering
  output logic            ack_o   // Operation done pulse
);
  logic [4:0] cnt;
  // One pulse per request; count parks past the delay until req drops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt   <= 5'h00;
      ack_o <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      if (!req_i) cnt <= 5'h00;
      else if (cnt == {1'b0, dly_i}) begin
        ack_o <= 1'b1;
        cnt   <= cnt + 5'h01;
      end else if (cnt < {1'b0, dly_i}) cnt <= cnt + 5'h01;
    end
  end
endmodule

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the diskette function sequencer
// Assumes: Design acks every bus access one cycle after it is taken
// Notes:   Fill length shortened to 4 words through WORDS_12
`timescale 1ns/1ps
module tb;
  localparam int NW = 4;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, pwr = 0, crc = 0, ack, req, unl;
  logic seek = 0, rdy = 1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic [3:0]  dly = 4'h2;
  logic [11:0] q, bf [NW];
  logic [11:0] sec, trk;
  ffs_pkg::ffs_drv_cmd_t dc, cap;
  int err_count = 0, total_checks = 0;
  logic wack, irq;
  logic [11:0] brd;
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (req) cap <= dc;
  ffs_sequencer #(.WORDS_12(NW)) ffs_sequencer_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(wack), .irq_o(irq), .pwr_ok_i(pwr),
    .head_unload_o(unl), .drv_cmd_o(dc), .drv_req_o(req), .drv_ack_i(ack),
    .drv_seek_err_i(seek), .drv_crc_err_i(crc), .drv_dd_i(1'b0), .drv_rdy_i(rdy),
    .drv_buf_addr_i(7'h00), .drv_buf_we_i(req), .drv_buf_wdata_i(12'h000),
    .drv_buf_rdata_o(brd));
  ffs_drive_model ffs_drive_model_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .dly_i(dly),
    .ack_o(ack));
  task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [12:0] d);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {19'h0, d[12] ^ ~^d[11:0], d[11:0]};
    n = 0;
    do begin @(posedge clk_i); n++; end while (wack !== 1'b1 && n < 50);
    q = rdat[11:0];
    cyc <= 1'b0;
    if (n >= 50) chk("ack", 12'h0, 12'h1);
  endtask
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin wb(0, ffs_pkg::ADDR_FLAGS, 0); n++; end while (q[b] !== 1'b1 && n < 400);
    if (n >= 400) chk("poll", 12'h0, 12'h1);
  endtask
  task automatic cmd(input logic [2:0] fn, input logic drv);
    poll(ffs_pkg::FL_DONE);
    wb(1, ffs_pkg::ADDR_FLAGS, 12'h005);
    wb(1, ffs_pkg::ADDR_CMD, {7'h0, drv, fn, 1'b1});
  endtask
  task automatic xfer(input logic w, input logic [11:0] d);
    poll(ffs_pkg::FL_TR);
    wb(1, ffs_pkg::ADDR_FLAGS, 12'h002);
    wb(w, ffs_pkg::ADDR_DATA, d);
  endtask
  task automatic fin(input string nm, input logic e, input logic [11:0] m, input logic [11:0] v);
    poll(ffs_pkg::FL_DONE);
    chk({nm, " err"}, {11'h0, q[ffs_pkg::FL_ERR]}, {11'h0, e});
    wb(0, ffs_pkg::ADDR_DATA, 0);
    chk({nm, " word"}, q & m, v);
    $display("test %s done", nm);
  endtask
  task automatic sector(input logic [2:0] fn, input logic drv, input logic [11:0] t);
    sec = 12'($urandom_range(1, 26));
    trk = t;
    dly <= 4'($urandom);
    cmd(fn, drv);
    xfer(1, sec);
    xfer(1, trk);
  endtask
  initial begin
    void'($urandom(32'h67c2aec9));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    pwr   <= 1'b1;
    fin("init", 0, ffs_pkg::MASK_ID, ffs_pkg::MASK_ID);
    chk("unload", {11'h0, unl}, 12'h0);
    wb(1, ffs_pkg::ADDR_CTRL, 12'h001);
    cmd(ffs_pkg::FN_FILL, 0);
    for (int i = 0; i < NW; i++) begin
      bf[i] = 12'($urandom);
      if (i == NW - 1) chk("early done", {11'h0, q[ffs_pkg::FL_DONE]}, 12'h0);
      xfer(1, bf[i]);
    end
    fin("fill", 0, 12'hFFF, 12'h000);
    chk("irq", {11'h0, irq}, 12'h1);
    for (int k = 0; k < 2; k++) begin
      cmd(ffs_pkg::FN_EMPTY, 1'(k));
      for (int i = 0; i < NW; i++) begin
        xfer(0, 0);
        chk("empty", q, bf[i]);
      end
      fin("empty", 0, ffs_pkg::MASK_CRC | ffs_pkg::MASK_PAR, 12'h000);
      sector(k ? ffs_pkg::FN_WDEL : ffs_pkg::FN_WRITE, 1'(k), 12'($urandom_range(0, 76)));
      fin("write", 0, ffs_pkg::MASK_DD, k ? ffs_pkg::MASK_DD : 12'h000);
      chk("drive", {6'h0, cap.sel, cap.sector}, {6'h0, 1'(k), sec[4:0]});
      chk("track", {5'h0, cap.track}, trk);
    end
    poll(ffs_pkg::FL_DONE);
    wb(1, ffs_pkg::ADDR_FLAGS, 12'h005);
    wb(1, ffs_pkg::ADDR_CMD, 12'h041);
    for (int i = 0; i < 128; i++) begin
      xfer(1, 12'(i));
    end
    fin("fill8", 0, 12'hFFF, ffs_pkg::MASK_DD);
    crc <= 1'b1;
    sector(ffs_pkg::FN_READ, 0, 12'h04C);
    fin("read crc", 1, ffs_pkg::MASK_CRC, ffs_pkg::MASK_CRC);
    crc <= 1'b0;
    poll(ffs_pkg::FL_DONE);
    wb(1, ffs_pkg::ADDR_FLAGS, 12'h005);
    wb(1, ffs_pkg::ADDR_CMD, 13'h1000);
    fin("parity", 1, ffs_pkg::MASK_PAR, ffs_pkg::MASK_PAR);
    seek <= 1'b1;
    sector(ffs_pkg::FN_WRITE, 0, 12'h010);
    fin("seek", 1, 12'hFFF, 12'h000);
    seek <= 1'b0;
    sector(ffs_pkg::FN_WRITE, 0, 12'h04D);
    fin("bad track", 1, 12'hFFF, 12'h000);
    cmd(ffs_pkg::FN_RERR, 0);
    fin("error code", 0, 12'h0FF, {4'h0, ffs_pkg::ERRC_TRACK});
    rdy <= 1'($urandom);
    cmd(ffs_pkg::FN_RSTAT, 0);
    fin("status", 0, 12'hFFF, rdy ? ffs_pkg::MASK_RDY : 12'h000);
    pwr <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("unload low", {11'h0, unl}, 12'h001);
    pwr <= 1'b1;
    fin("power", 0, ffs_pkg::MASK_ID, ffs_pkg::MASK_ID);
    cmd(ffs_pkg::FN_FILL, 0);
    xfer(1, 12'h0A5);
    wb(1, ffs_pkg::ADDR_CTRL, 12'h002);
    fin("abort", 0, ffs_pkg::MASK_ID, ffs_pkg::MASK_ID);
    final_report;
  end
  // Budget well above the expected run of a few thousand cycles
  initial begin
    #100000;
    err_count++;
    final_report;
  end
endmodule
